//--- tsg_pkg.sv
// How it works
// - pattern_a and pattern_b each hold a programmable pattern up to 16 bits.
// - pattern_a and pattern_b may append a burst of up to 256 equal bits.
// - pattern_c and pattern_d hold at most 8 bits and never burst.
// - pair01_length and pair23_length complete each definition and delimit the pattern.
// - bits above the length are ignored; sending runs from length down to zero.
// - frame_control can place pattern_a, pattern_b or pattern_c before the data.
// - frame_control can place pattern_b, pattern_c or pattern_d after the data.
// - a and b share one timing/shape set; c and d share another.
// - each shared set gives bit clock, subcarrier, pulse type/length and envelope.
// - data between symbols comes from the bit generator when data_coding_type is zero.
package tsg_pkg;
   localparam int PAT_AB_W = 16;
   localparam int PAT_CD_W = 8;
   localparam int LEN_AB_W = 4;
   localparam int LEN_CD_W = 3;
   localparam int BURST_W = 8;
   localparam int DIV_W = 8;
   localparam int SUBC_W = 8;
   localparam int PTYPE_W = 2;
   localparam int PLEN_W = 4;
   localparam int ENV_W = 2;
   localparam int DCODE_W = 4;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = 2;
   localparam int FIFO_LAST_POS = 1;
   localparam int FIFO_BIT_POS = 0;

   localparam logic [1:0] START_NONE = 2'h0;
   localparam logic [1:0] START_A = 2'h1;
   localparam logic [1:0] START_B = 2'h2;
   localparam logic [1:0] START_C = 2'h3;
   localparam logic [1:0] END_NONE = 2'h0;
   localparam logic [1:0] END_B = 2'h1;
   localparam logic [1:0] END_C = 2'h2;
   localparam logic [1:0] END_D = 2'h3;
   localparam logic [3:0] DCODE_DEFAULT = 4'h0;

   localparam logic [1:0] SYM_A = 2'h0;
   localparam logic [1:0] SYM_B = 2'h1;
   localparam logic [1:0] SYM_C = 2'h2;
   localparam logic [1:0] SYM_D = 2'h3;
   localparam logic [3:0] IDX_CD_MAX = 4'h7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SOF = 3'b001,
      ST_SOF_BURST = 3'b010,
      ST_DATA = 3'b011,
      ST_EOF = 3'b100,
      ST_EOF_BURST = 3'b101
   } tsg_state_t;

   typedef struct packed {
      tsg_state_t st;
      logic [1:0] sym;
      logic [3:0] idx;
      logic [BURST_W-1:0] burst_cnt;
      logic [DIV_W-1:0] div_cnt;
      logic tx_bit;
      logic bit_stb;
      logic tx_symbol;
      logic tx_pair;
      logic [SUBC_W-1:0] tx_subc_div;
      logic [PTYPE_W-1:0] tx_pulse_type;
      logic [PLEN_W-1:0] tx_pulse_len;
      logic [ENV_W-1:0] tx_env_type;
      logic busy;
      logic frame_done;
   } tsg_top_st_t;

   localparam tsg_top_st_t TOP_RESET = '0;
endpackage

//--- tsg_fifo_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tsg_fifo_if #(parameter int W = 2);
   logic push_valid;
   logic [W-1:0] push_data;
   logic push_ready;
   logic pop_valid;
   logic [W-1:0] pop_data;
   logic pop_ready;
   modport fifo (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data);
   modport user (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data);
endinterface // tsg_fifo_if
`default_nettype wire

//--- tsg_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module tsg_fifo #(
   parameter int W = 2,
   parameter int D = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // both sides
   tsg_fifo_if.fifo f
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
      logic in_rdy;
   } tsg_fifo_st_t;

   tsg_fifo_st_t s_r;
   tsg_fifo_st_t s_nxt;
   logic push;
   logic pop;

   assign f.push_ready = s_r.in_rdy;
   assign f.pop_valid = (s_r.cnt != '0);
   assign f.pop_data = s_r.mem[s_r.rp];
   assign push = f.push_valid && s_r.in_rdy;
   assign pop = f.pop_ready && (s_r.cnt != '0);

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(D - 1)) ? '0 : p + PW'(1);
   endfunction

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = f.push_data;
         s_nxt.wp = ptr_inc(s_r.wp);
      end
      if (pop) begin
         s_nxt.rp = ptr_inc(s_r.rp);
      end
      s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
      // registered ready keeps the upstream path free of the pop logic
      s_nxt.in_rdy = (s_nxt.cnt != CW'(D));
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{mem: '0, wp: '0, rp: '0, cnt: '0, in_rdy: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule // tsg_fifo
`default_nettype wire

//--- tsg_top.sv
`timescale 1ns/10ps
`default_nettype none
module tsg_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // symbol definitions
   input wire logic [tsg_pkg::PAT_AB_W-1:0] pattern_a_def,
   input wire logic [tsg_pkg::PAT_AB_W-1:0] pattern_b_def,
   input wire logic [tsg_pkg::PAT_CD_W-1:0] pattern_c_def,
   input wire logic [tsg_pkg::PAT_CD_W-1:0] pattern_d_def,
   // pair01_length and pair23_length fields
   input wire logic [tsg_pkg::LEN_AB_W-1:0] pair01_length_a,
   input wire logic [tsg_pkg::LEN_AB_W-1:0] pair01_length_b,
   input wire logic [tsg_pkg::LEN_CD_W-1:0] pair23_length_c,
   input wire logic [tsg_pkg::LEN_CD_W-1:0] pair23_length_d,
   // bursts of pattern_a and pattern_b
   input wire logic burst_en_a,
   input wire logic burst_level_a,
   input wire logic [tsg_pkg::BURST_W-1:0] burst_len_a,
   input wire logic burst_en_b,
   input wire logic burst_level_b,
   input wire logic [tsg_pkg::BURST_W-1:0] burst_len_b,
   // shared configuration of pattern_a/pattern_b
   input wire logic [tsg_pkg::DIV_W-1:0] cfg01_bitclk_div,
   input wire logic [tsg_pkg::SUBC_W-1:0] cfg01_subc_div,
   input wire logic [tsg_pkg::PTYPE_W-1:0] cfg01_pulse_type,
   input wire logic [tsg_pkg::PLEN_W-1:0] cfg01_pulse_len,
   input wire logic [tsg_pkg::ENV_W-1:0] cfg01_env_type,
   // shared configuration of pattern_c/pattern_d
   input wire logic [tsg_pkg::DIV_W-1:0] cfg23_bitclk_div,
   input wire logic [tsg_pkg::SUBC_W-1:0] cfg23_subc_div,
   input wire logic [tsg_pkg::PTYPE_W-1:0] cfg23_pulse_type,
   input wire logic [tsg_pkg::PLEN_W-1:0] cfg23_pulse_len,
   input wire logic [tsg_pkg::ENV_W-1:0] cfg23_env_type,
   // frame_control
   input wire logic [1:0] frame_control_start_sel,
   input wire logic [1:0] frame_control_end_sel,
   input wire logic [tsg_pkg::DCODE_W-1:0] data_coding_type,
   input wire logic [tsg_pkg::DIV_W-1:0] data_bitclk_div,
   input wire logic frame_start,
   // data from the bit generator
   input wire logic data_valid,
   input wire logic data_bit,
   input wire logic data_last,
   output logic data_ready,
   // towards the modulator
   output logic tx_bit,
   output logic tx_bit_stb,
   output logic tx_symbol,
   output logic tx_pair,
   output logic [tsg_pkg::SUBC_W-1:0] tx_subc_div,
   output logic [tsg_pkg::PTYPE_W-1:0] tx_pulse_type,
   output logic [tsg_pkg::PLEN_W-1:0] tx_pulse_len,
   output logic [tsg_pkg::ENV_W-1:0] tx_env_type,
   // status
   output logic busy,
   output logic frame_done
);
   import tsg_pkg::*;

   tsg_top_st_t s;
   tsg_top_st_t n;
   logic want_data;
   logic want_end;
   logic want_done;
   logic cur_bit;
   logic cur_lvl;

   tsg_fifo_if #(.W(FIFO_W)) fifo_c ();

   tsg_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .f(fifo_c.fifo)
   );

   assign fifo_c.push_valid = data_valid;
   assign fifo_c.push_data = {data_last, data_bit};
   // only a bit-clock tick of the data phase drains the buffer
   assign fifo_c.pop_ready = (s.st == ST_DATA) && (s.div_cnt == '0);
   assign data_ready = fifo_c.push_ready;

   function automatic logic [3:0] sym_len(input logic [1:0] sym,
                                          input logic [3:0] la, input logic [3:0] lb,
                                          input logic [2:0] lc, input logic [2:0] ld);
      unique case (sym)
         SYM_A: sym_len = la;
         SYM_B: sym_len = lb;
         SYM_C: sym_len = {1'b0, lc};
         SYM_D: sym_len = {1'b0, ld};
      endcase
   endfunction

   function automatic logic [DIV_W-1:0] reload(input logic [DIV_W-1:0] div);
      // zero is taken as one cycle per bit
      reload = (div == '0) ? '0 : div - DIV_W'(1);
   endfunction

   // idx beyond the programmed length is never reached
   always_comb begin
      unique case (s.sym)
         SYM_A: cur_bit = pattern_a_def[s.idx];
         SYM_B: cur_bit = pattern_b_def[s.idx];
         SYM_C: cur_bit = pattern_c_def[s.idx[2:0]];
         SYM_D: cur_bit = pattern_d_def[s.idx[2:0]];
      endcase
      cur_lvl = s.sym[0] ? burst_level_b : burst_level_a;
   end

   always_comb begin
      n = s;
      want_data = 1'b0;
      want_end = 1'b0;
      want_done = 1'b0;
      n.bit_stb = 1'b0;
      n.frame_done = 1'b0;
      unique case (s.st)
         ST_IDLE: begin
            if (frame_start) begin
               n.busy = 1'b1;
               n.div_cnt = '0;
               if (frame_control_start_sel == START_NONE) begin
                  want_data = 1'b1;
               end else begin
                  n.st = ST_SOF;
                  n.sym = frame_control_start_sel - 2'h1;
                  n.idx = sym_len(n.sym, pair01_length_a, pair01_length_b,
                                  pair23_length_c, pair23_length_d);
               end
            end
         end
         ST_SOF, ST_EOF: begin
            if (s.div_cnt != '0) begin
               n.div_cnt = s.div_cnt - DIV_W'(1);
            end else begin
               n.tx_bit = cur_bit;
               n.bit_stb = 1'b1;
               n.tx_symbol = 1'b1;
               n.tx_pair = s.sym[1];
               n.tx_subc_div = s.sym[1] ? cfg23_subc_div : cfg01_subc_div;
               n.tx_pulse_type = s.sym[1] ? cfg23_pulse_type : cfg01_pulse_type;
               n.tx_pulse_len = s.sym[1] ? cfg23_pulse_len : cfg01_pulse_len;
               n.tx_env_type = s.sym[1] ? cfg23_env_type : cfg01_env_type;
               n.div_cnt = reload(s.sym[1] ? cfg23_bitclk_div : cfg01_bitclk_div);
               if (s.idx != 4'h0) begin
                  n.idx = s.idx - 4'h1;
               end else if (!s.sym[1] && (s.sym[0] ? burst_en_b : burst_en_a)) begin
                  // burst only for the first pair
                  n.st = (s.st == ST_SOF) ? ST_SOF_BURST : ST_EOF_BURST;
                  n.burst_cnt = s.sym[0] ? burst_len_b : burst_len_a;
               end else if (s.st == ST_SOF) begin
                  want_data = 1'b1;
               end else begin
                  want_done = 1'b1;
               end
            end
         end
         ST_SOF_BURST, ST_EOF_BURST: begin
            if (s.div_cnt != '0) begin
               n.div_cnt = s.div_cnt - DIV_W'(1);
            end else begin
               n.tx_bit = cur_lvl;
               n.bit_stb = 1'b1;
               n.div_cnt = reload(cfg01_bitclk_div);
               if (s.burst_cnt != '0) begin
                  n.burst_cnt = s.burst_cnt - BURST_W'(1);
               end else if (s.st == ST_SOF_BURST) begin
                  want_data = 1'b1;
               end else begin
                  want_done = 1'b1;
               end
            end
         end
         ST_DATA: begin
            if (s.div_cnt != '0) begin
               n.div_cnt = s.div_cnt - DIV_W'(1);
            end else if (fifo_c.pop_valid) begin
               n.tx_bit = fifo_c.pop_data[FIFO_BIT_POS];
               n.bit_stb = 1'b1;
               n.tx_symbol = 1'b0;
               n.div_cnt = reload(data_bitclk_div);
               want_end = fifo_c.pop_data[FIFO_LAST_POS];
            end
         end
         default: begin
            n.st = ST_IDLE;
            n.busy = 1'b0;
         end
      endcase
      // the phase timer runs on so the last bit keeps its full period
      if (want_data) begin
         if (data_coding_type == DCODE_DEFAULT) begin
            n.st = ST_DATA;
         end else begin
            want_end = 1'b1;
         end
      end
      if (want_end) begin
         if (frame_control_end_sel != END_NONE) begin
            n.st = ST_EOF;
            n.sym = frame_control_end_sel;
            n.idx = sym_len(n.sym, pair01_length_a, pair01_length_b,
                            pair23_length_c, pair23_length_d);
         end else begin
            want_done = 1'b1;
         end
      end
      if (want_done) begin
         n.st = ST_IDLE;
         n.busy = 1'b0;
         n.frame_done = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= TOP_RESET;
      end else begin
         s <= n;
      end
   end

   assign tx_bit = s.tx_bit;
   assign tx_bit_stb = s.bit_stb;
   assign tx_symbol = s.tx_symbol;
   assign tx_pair = s.tx_pair;
   assign tx_subc_div = s.tx_subc_div;
   assign tx_pulse_type = s.tx_pulse_type;
   assign tx_pulse_len = s.tx_pulse_len;
   assign tx_env_type = s.tx_env_type;
   assign busy = s.busy;
   assign frame_done = s.frame_done;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_sym_tick;
      ((s.st == ST_SOF) || (s.st == ST_EOF)) && (s.div_cnt == '0);
   endsequence
   sequence seq_go(logic [1:0] sel);
      (s.st == ST_IDLE) && frame_start && (frame_control_start_sel == sel);
   endsequence

   property p_len_a;
      seq_go(START_A) |=> (s.st == ST_SOF) && (s.sym == SYM_A) &&
                          (s.idx == $past(pair01_length_a));
   endproperty
   a_len_a: assert property (p_len_a) else $error("pattern_a length not loaded");

   property p_burst;
      (s.st == ST_SOF_BURST || s.st == ST_EOF_BURST) && (s.div_cnt == '0)
         |=> s.bit_stb && (s.tx_bit == $past(cur_lvl));
   endproperty
   a_burst: assert property (p_burst) else $error("burst bit wrong level");

   property p_cd_bound;
      s.busy && s.sym[1] |-> (s.st != ST_SOF_BURST) && (s.st != ST_EOF_BURST) &&
                             (s.idx <= IDX_CD_MAX);
   endproperty
   a_cd_bound: assert property (p_cd_bound) else $error("short pattern index too high");

   property p_bit_order;
      seq_sym_tick |=> s.bit_stb && s.tx_symbol && (s.tx_bit == $past(cur_bit));
   endproperty
   a_bit_order: assert property (p_bit_order) else $error("symbol bit mismatch");

   property p_start_c;
      seq_go(START_C) |=> (s.st == ST_SOF) && (s.sym == SYM_C) &&
                          (s.idx == {1'b0, $past(pair23_length_c)});
   endproperty
   a_start_c: assert property (p_start_c) else $error("pattern_c not started");

   property p_end_d;
      (s.st == ST_DATA) && (s.div_cnt == '0) && fifo_c.pop_valid &&
      fifo_c.pop_data[FIFO_LAST_POS] && (frame_control_end_sel == END_D)
         |=> (s.st == ST_EOF) && (s.sym == SYM_D);
   endproperty
   a_end_d: assert property (p_end_d) else $error("pattern_d not sent after data");

   property p_pair23_cfg;
      s.bit_stb && s.tx_symbol && s.tx_pair |-> (s.tx_subc_div == $past(cfg23_subc_div)) &&
                                                (s.tx_env_type == $past(cfg23_env_type));
   endproperty
   a_pair23_cfg: assert property (p_pair23_cfg) else $error("pair23 config not used");

   property p_data_gate;
      (s.st != ST_DATA) ##1 (s.st == ST_DATA) |-> ($past(data_coding_type) == DCODE_DEFAULT);
   endproperty
   a_data_gate: assert property (p_data_gate) else $error("data phase, other coding");

   property p_spacing;
      s.bit_stb && s.tx_symbol && !s.tx_pair && (cfg01_bitclk_div > 8'h01) |=> !s.bit_stb;
   endproperty
   a_spacing: assert property (p_spacing) else $error("symbol bits too close");
endmodule // tsg_top
`default_nettype wire

//--- tsg_mod_model.sv
`timescale 1ns/10ps
`default_nettype none
module tsg_mod_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // from the symbol generator
   input wire logic tx_bit,
   input wire logic tx_bit_stb,
   input wire logic tx_symbol,
   input wire logic tx_pair,
   input wire logic [tsg_pkg::SUBC_W-1:0] tx_subc_div,
   input wire logic [tsg_pkg::PTYPE_W-1:0] tx_pulse_type,
   input wire logic [tsg_pkg::PLEN_W-1:0] tx_pulse_len,
   input wire logic [tsg_pkg::ENV_W-1:0] tx_env_type,
   input wire logic frame_done
);
   import tsg_pkg::*;
   // one entry per strobe: bit, symbol flag, pair, then the shaping set
   logic [18:0] log_q[$];
   int stamp_q[$];
   int cyc;
   int done_cnt;
   task automatic clear();
      log_q.delete();
      stamp_q.delete();
      done_cnt = 0;
   endtask
   // a modulator cannot stall, so each strobed bit is simply taken as it comes
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc <= 0;
      end else begin
         cyc <= cyc + 1;
         if (tx_bit_stb === 1'h1) begin
            log_q.push_back({tx_bit, tx_symbol, tx_pair, tx_subc_div, tx_pulse_type,
                             tx_pulse_len, tx_env_type});
            stamp_q.push_back(cyc);
         end
         if (frame_done === 1'h1)
            done_cnt++;
      end
   end
endmodule // tsg_mod_model
`default_nettype wire

//--- tx_symbol_generator_bench.sv
`timescale 1ns/10ps
`default_nettype none
module tx_symbol_generator_bench;
   import tsg_pkg::*;
   typedef struct {
      logic [1:0] ss, es;
      logic [3:0] dct, la, lb;
      logic [2:0] lc, ld;
      logic bea, lva, beb, lvb;
      logic [7:0] bla, blb, d01, d23;
      int nd, nexp;
   } tsg_row_t;
   tsg_row_t rows [5] = '{
      '{START_A, END_B, 4'h1, 4'h5, 4'h3, 3'h0, 3'h0, 1'h0, 1'h0, 1'h0, 1'h0,
        8'h00, 8'h00, 8'h02, 8'h01, 0, 10},
      '{START_B, END_C, 4'h1, 4'h0, 4'h2, 3'h7, 3'h0, 1'h0, 1'h0, 1'h1, 1'h1,
        8'h00, 8'h02, 8'h01, 8'h03, 0, 14},
      '{START_C, END_D, 4'h0, 4'h0, 4'h0, 3'h0, 3'h4, 1'h0, 1'h0, 1'h0, 1'h0,
        8'h00, 8'h00, 8'h01, 8'h00, 3, 9},
      '{START_A, END_NONE, 4'h9, 4'hf, 4'h0, 3'h0, 3'h0, 1'h1, 1'h0, 1'h0, 1'h0,
        8'hff, 8'h00, 8'h00, 8'h01, 0, 272},
      '{START_NONE, END_B, 4'h0, 4'h0, 4'h0, 3'h0, 3'h0, 1'h0, 1'h0, 1'h1, 1'h0,
        8'h00, 8'h00, 8'h04, 8'h01, 1, 3}};
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [15:0] pattern_a_def = 16'h0, pattern_b_def = 16'h0;
   logic [7:0] pattern_c_def = 8'h0, pattern_d_def = 8'h0;
   logic [3:0] pair01_length_a = 4'h0, pair01_length_b = 4'h0;
   logic [2:0] pair23_length_c = 3'h0, pair23_length_d = 3'h0;
   logic burst_en_a = 1'h0, burst_level_a = 1'h0, burst_en_b = 1'h0, burst_level_b = 1'h0;
   logic [7:0] burst_len_a = 8'h0, burst_len_b = 8'h0;
   logic [7:0] cfg01_bitclk_div = 8'h0, cfg01_subc_div = 8'h0;
   logic [7:0] cfg23_bitclk_div = 8'h0, cfg23_subc_div = 8'h0;
   logic [1:0] cfg01_pulse_type = 2'h0, cfg01_env_type = 2'h0;
   logic [1:0] cfg23_pulse_type = 2'h0, cfg23_env_type = 2'h0;
   logic [3:0] cfg01_pulse_len = 4'h0, cfg23_pulse_len = 4'h0, data_coding_type = 4'h0;
   logic [1:0] frame_control_start_sel = 2'h0, frame_control_end_sel = 2'h0;
   logic [7:0] data_bitclk_div = 8'h0;
   logic frame_start = 1'h0, data_valid = 1'h0, data_bit = 1'h0, data_last = 1'h0;
   logic data_ready, tx_bit, tx_bit_stb, tx_symbol, tx_pair, busy, frame_done;
   logic [7:0] tx_subc_div;
   logic [1:0] tx_pulse_type, tx_env_type;
   logic [3:0] tx_pulse_len;
   wire logic [15:0] cfg01 = {cfg01_subc_div, cfg01_pulse_type, cfg01_pulse_len, cfg01_env_type};
   wire logic [15:0] cfg23 = {cfg23_subc_div, cfg23_pulse_type, cfg23_pulse_len, cfg23_env_type};
   int err_count = 0;
   int total_checks = 0;
   logic eb[$];
   logic ep[$];
   int ek[$];
   int ed[$];

   tsg_top uut (.sys_clk, .rst_n, .pattern_a_def, .pattern_b_def, .pattern_c_def,
      .pattern_d_def, .pair01_length_a, .pair01_length_b, .pair23_length_c, .pair23_length_d,
      .burst_en_a, .burst_level_a, .burst_len_a, .burst_en_b, .burst_level_b, .burst_len_b,
      .cfg01_bitclk_div, .cfg01_subc_div, .cfg01_pulse_type, .cfg01_pulse_len, .cfg01_env_type,
      .cfg23_bitclk_div, .cfg23_subc_div, .cfg23_pulse_type, .cfg23_pulse_len, .cfg23_env_type,
      .frame_control_start_sel, .frame_control_end_sel, .data_coding_type, .data_bitclk_div,
      .frame_start, .data_valid, .data_bit, .data_last, .data_ready, .tx_bit, .tx_bit_stb,
      .tx_symbol, .tx_pair, .tx_subc_div, .tx_pulse_type, .tx_pulse_len, .tx_env_type,
      .busy, .frame_done);
   tsg_mod_model model (.sys_clk, .rst_n, .tx_bit, .tx_bit_stb, .tx_symbol, .tx_pair,
      .tx_subc_div, .tx_pulse_type, .tx_pulse_len, .tx_env_type, .frame_done);

   always #12.5 sys_clk = ~sys_clk;

   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic timeout();
      err_count++;
      report_and_stop();
   endtask
   function automatic int dv(logic [7:0] x);
      return (x == 8'h0) ? 1 : int'(x);
   endfunction
   function automatic logic dbit(int i);
      return logic'(i % 3 == 0);
   endfunction
   task automatic add(logic b, int k, logic p, int d);
      eb.push_back(b);
      ek.push_back(k);
      ep.push_back(p);
      ed.push_back(d);
   endtask
   task automatic add_sym(logic [1:0] sym, tsg_row_t r);
      case (sym)
         SYM_A: begin
            for (int i = r.la; i >= 0; i--)
               add(pattern_a_def[i], 1, 1'h0, dv(r.d01));
            if (r.bea)
               for (int i = 0; i <= r.bla; i++)
                  add(r.lva, 2, 1'h0, dv(r.d01));
         end
         SYM_B: begin
            for (int i = r.lb; i >= 0; i--)
               add(pattern_b_def[i], 1, 1'h0, dv(r.d01));
            if (r.beb)
               for (int i = 0; i <= r.blb; i++)
                  add(r.lvb, 2, 1'h0, dv(r.d01));
         end
         SYM_C: begin
            for (int i = r.lc; i >= 0; i--)
               add(pattern_c_def[i], 1, 1'h1, dv(r.d23));
         end
         default: begin
            for (int i = r.ld; i >= 0; i--)
               add(pattern_d_def[i], 1, 1'h1, dv(r.d23));
         end
      endcase
   endtask
   task automatic apply(tsg_row_t r, int k);
      {frame_control_start_sel, frame_control_end_sel, data_coding_type} = {r.ss, r.es, r.dct};
      {pair01_length_a, pair01_length_b} = {r.la, r.lb};
      {pair23_length_c, pair23_length_d} = {r.lc, r.ld};
      {burst_en_a, burst_level_a, burst_len_a} = {r.bea, r.lva, r.bla};
      {burst_en_b, burst_level_b, burst_len_b} = {r.beb, r.lvb, r.blb};
      {cfg01_bitclk_div, cfg23_bitclk_div, data_bitclk_div} = {r.d01, r.d23, 8'(k % 4)};
      pattern_a_def = 16'hb5c3 + 16'(k * 37);
      pattern_b_def = 16'h6e19 - 16'(k * 53);
      pattern_c_def = 8'hd6 ^ 8'(k * 29);
      pattern_d_def = 8'h9b + 8'(k * 7);
      {cfg01_subc_div, cfg01_pulse_type, cfg01_pulse_len, cfg01_env_type} =
         16'h114e + 16'(k * 2339);
      {cfg23_subc_div, cfg23_pulse_type, cfg23_pulse_len, cfg23_env_type} =
         16'h8a35 ^ 16'(k * 12609);
   endtask
   task automatic build(tsg_row_t r);
      eb.delete();
      ek.delete();
      ep.delete();
      ed.delete();
      model.clear();
      if (r.ss != START_NONE) add_sym(r.ss - 2'h1, r);
      if (r.dct == DCODE_DEFAULT)
         for (int i = 0; i < r.nd; i++)
            add(dbit(i), 0, 1'h0, dv(data_bitclk_div));
      if (r.es != END_NONE) add_sym(r.es, r);
   endtask
   task automatic push_data(int n);
      int w;
      for (int i = 0; i < n; i++) begin
         data_valid = 1'h1;
         data_bit = dbit(i);
         data_last = logic'(i == n - 1);
         w = 0;
         while (data_ready !== 1'h1 && w < 100) begin
            tick(1);
            w++;
         end
         if (w == 100) timeout();
         tick(1);
      end
      data_valid = 1'h0;
   endtask
   task automatic start_frame(output int s0);
      frame_start = 1'h1;
      s0 = model.cyc;
      tick(1);
      frame_start = 1'h0;
      tick(1);
      check(busy, 1'h1);
      // a second start while busy must change nothing
      frame_start = 1'h1;
      tick(1);
      frame_start = 1'h0;
   endtask
   task automatic finish_frame(int s0, logic strict);
      int n;
      logic [18:0] e;
      n = 0;
      while (busy !== 1'h0 && n < 3000) begin
         tick(1);
         n++;
      end
      if (n == 3000) timeout();
      tick(2);
      check(model.log_q.size(), eb.size());
      check(model.done_cnt, 1);
      // start taken at the first edge, strobe registered at the second
      if (model.stamp_q.size() > 0)
         check(model.stamp_q[0] - s0, 2);
      for (int i = 0; i < eb.size() && i < model.log_q.size(); i++) begin
         e = model.log_q[i];
         check(e[18], eb[i]);
         check(e[17], logic'(ek[i] != 0));
         if (ek[i] == 1) check(e[16], ep[i]);
         if (ek[i] == 1) check(e[15:0], ep[i] ? cfg23 : cfg01);
         if (i + 1 < model.stamp_q.size() && (ek[i + 1] != 0 || strict))
            check(model.stamp_q[i + 1] - model.stamp_q[i], ed[i]);
      end
   endtask

   initial begin
      int s0;
      tsg_row_t r;
      tick(5);
      rst_n = 1'h1;
      check({busy, tx_bit_stb, frame_done, tx_bit, data_ready}, 5'h01);
      foreach (rows[k]) begin
         r = rows[k];
         apply(r, k);
         push_data(r.nd);
         build(r);
         check(eb.size(), r.nexp);
         start_frame(s0);
         finish_frame(s0, 1'h1);
      end
      // fill the buffer until it refuses, then drain it in a data-only frame
      r = rows[4];
      r.ss = START_NONE;
      r.es = END_NONE;
      r.nd = 8;
      apply(r, 5);
      data_valid = 1'h1;
      for (int i = 0; i < 8; i++) begin
         {data_bit, data_last} = {dbit(i), logic'(i == 7)};
         check(data_ready, 1'h1);
         tick(1);
      end
      data_bit = 1'h1;
      repeat (3) begin
         check(data_ready, 1'h0);
         tick(1);
      end
      data_valid = 1'h0;
      build(r);
      start_frame(s0);
      finish_frame(s0, 1'h1);
      check(data_ready, 1'h1);
      // data phase holds while the buffer is empty
      r = rows[2];
      r.nd = 2;
      apply(r, 6);
      build(r);
      start_frame(s0);
      tick(30);
      check(busy, 1'h1);
      check(model.log_q.size(), 1);
      push_data(2);
      finish_frame(s0, 1'h0);
      // reset in mid-frame
      apply(rows[3], 3);
      build(rows[3]);
      start_frame(s0);
      tick(10);
      rst_n = 1'h0;
      tick(1);
      check({busy, tx_bit_stb, frame_done, data_ready}, 4'h1);
      rst_n = 1'h1;
      tick(2);
      check(busy, 1'h0);
      report_and_stop();
   end
endmodule // tx_symbol_generator_bench
`default_nettype wire
